// ---- logic/smc_params.svh ----
// timing constants, bit indices and event codes for the line modem supervisor
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define SMC_CLK_MHZ          125
`define SMC_TICK_MS          1
`define SMC_TICK_CYCLES      (`SMC_CLK_MHZ * 1000 * `SMC_TICK_MS)
`define SMC_CARRIER_LOSS_MS  128
`define SMC_CALL_TIMEOUT_S   65
`define SMC_CALL_TIMEOUT_MS  (`SMC_CALL_TIMEOUT_S * 1000)
`define SMC_REINIT_WAIT_S    3
`define SMC_REINIT_WAIT_MS   (`SMC_REINIT_WAIT_S * 1000)
`define SMC_CWAIT_MS         1000
`define SMC_CTS_REL_MS       100
`define SMC_HDX_BIT          4
`define SMC_LINE_REG_INDEX   13
`define SMC_EV_NONE          2'h0
`define SMC_EV_DISCONNECT    2'h1
`define SMC_EV_RING          2'h2
`define SMC_EV_CARRIER_LOSS  2'h3
`endif

// ---- logic/smc_pkg.sv ----
// types for the line modem supervisor
package smc_pkg;
   typedef enum logic [1:0] {
      SMC_CALL_IDLE,
      SMC_CALL_RUN,
      SMC_CALL_WAIT
   } smc_call_st_t;
   typedef enum logic [1:0] {
      SMC_CTS_IDLE,
      SMC_CTS_WAIT,
      SMC_CTS_HOLD
   } smc_cts_st_t;
   typedef struct packed {
      logic [1:0]   rdy_s;
      logic [1:0]   ring_s;
      logic [1:0]   car_s;
      logic [1:0]   cts_s;
      logic [1:0]   tm_s;
      logic [16:0]  tick_cnt;
      logic         tick;
      logic         rdy_smp;
      logic         rdy_seen;
      logic         ring_prev;
      logic         ring_arm;
      logic [7:0]   car_cnt;
      logic         car_lost;
      smc_call_st_t call_st;
      logic [16:0]  call_cnt;
      logic         dtr_block;
      logic         reinit;
      logic [9:0]   cw_cnt;
      logic         cw_flag;
      smc_cts_st_t  cts_st;
      logic [6:0]   cts_cnt;
      logic         cts_flag;
      logic         hdx;
      logic         ev_valid;
      logic [1:0]   ev_code;
      logic [7:0]   status;
   } smc_state_t;
endpackage : smc_pkg

// ---- logic/smc_modem_ctl.sv ----
// modem control supervisor: lockouts, signal watchers, timers, status
`include "smc_params.svh"
// Summary of operation
// - request to send locked out without modem ready
// - half duplex bit selects half or full
// - half duplex carrier holds silo, drops rts
// - half duplex transmit disables receiver
// - modem ready falling reports disconnect event
// - modem ready sampled once per tick
// - ring rise reported after one tick high
// - carrier off over 128 ms reports loss
// - call timer starts on ready, 65 s
// - call expiry drops dtr, reports disconnect
// - three second wait then reinitialize
// - every watcher runs concurrently
// - full duplex rts steady, dropped on errors
// - carrier wait timer flags unreleased link
// - cts release timed with timeout path
// - switch bypasses interlock for constant cts
// - status word readable by host
// - host writes modem control outputs
// - half duplex changes only by mode command
module smc_modem_ctl
   import smc_pkg::*;
#(
   parameter int TICK_CYCLES = `SMC_TICK_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       srst,
   input  wire logic       modem_ready,
   input  wire logic       ring_detect,
   input  wire logic       carrier_detect,
   input  wire logic       clear_to_send,
   input  wire logic       test_mode,
   input  wire logic       point_to_point,
   input  wire logic       header_valid,
   input  wire logic       line_error,
   input  wire logic       cts_interlock_bypass,
   input  wire logic       tx_request,
   input  wire logic       tx_active,
   input  wire logic       silo_has_data,
   input  wire logic       mode_cmd_valid,
   input  wire logic       mode_half_duplex,
   input  wire logic       wr_ctl_valid,
   input  wire logic [5:0] wr_ctl_data,
   output logic            request_to_send,
   output logic            data_terminal_ready,
   output logic            standby_select,
   output logic            remote_loopback,
   output logic            local_loopback,
   output logic            new_signal,
   output logic            freq_select,
   output logic            silo_to_sync_serial_transceiver,
   output logic            rx_enable,
   output logic            half_duplex,
   output logic [7:0]      modem_status,
   output logic            event_valid,
   output logic [1:0]      event_code,
   output logic            carrier_wait_timeout,
   output logic            cts_release_timeout,
   output logic            line_reinit
);
   smc_state_t s_q, s_d;
   logic [5:0] ctl_q;
   logic       rts_int;
   logic       tx_gate;

   // tick counter limit at counter width
   localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

   // saturating-free compare helper used by the call timer and reinit wait on call_cnt
   function automatic logic reached(input logic [16:0] cnt, input logic [16:0] lim);
      reached = (cnt >= lim);
   endfunction : reached

   // host-written modem controls; dtr gated by call expiry
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctl_q <= 6'h00;
      end else if (wr_ctl_valid) begin
         ctl_q <= wr_ctl_data;
      end
   end

   // interlock: ready lockout, half duplex carrier block, bypass switch
   always_comb begin
      tx_gate = !(s_q.hdx && s_q.car_s[1]);
      rts_int = s_q.rdy_s[1] && tx_gate && !line_error
                && (s_q.hdx ? (tx_request && silo_has_data) : 1'b1)
                && (cts_interlock_bypass || s_q.cts_st != SMC_CTS_HOLD);
   end

   always_comb begin
      s_d = s_q;
      s_d.ev_valid = 1'b0;
      s_d.ev_code  = `SMC_EV_NONE;
      s_d.reinit   = 1'b0;
      // pin synchronisers, second stage only is read
      s_d.rdy_s  = {s_q.rdy_s[0], modem_ready};
      s_d.ring_s = {s_q.ring_s[0], ring_detect};
      s_d.car_s  = {s_q.car_s[0], carrier_detect};
      s_d.cts_s  = {s_q.cts_s[0], clear_to_send};
      s_d.tm_s   = {s_q.tm_s[0], test_mode};
      // free-running millisecond tick
      if (s_q.tick_cnt == TICK_LAST) begin
         s_d.tick_cnt = 17'h00000;
         s_d.tick     = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 17'h00001;
         s_d.tick     = 1'b0;
      end
      // half duplex set only by mode definition
      if (mode_cmd_valid) begin
         s_d.hdx = mode_half_duplex;
      end
      // the flows below each advance independently on the tick
      if (s_q.tick) begin
         // modem ready watcher
         s_d.rdy_smp = s_q.rdy_s[1];
         if (s_q.rdy_s[1]) begin
            s_d.rdy_seen = 1'b1;
         end
         if (s_q.rdy_seen && s_q.rdy_smp && !s_q.rdy_s[1]) begin
            s_d.ev_valid = 1'b1;
            s_d.ev_code  = `SMC_EV_DISCONNECT;
         end
         // ring: arm on rise, report if still high next tick
         s_d.ring_prev = s_q.ring_s[1];
         s_d.ring_arm  = s_q.ring_s[1] && !s_q.ring_prev;
         if (s_q.ring_arm && s_q.ring_s[1]) begin
            s_d.ev_valid = 1'b1;
            s_d.ev_code  = `SMC_EV_RING;
         end
         // carrier loss counter, one report per drop
         if (s_q.car_s[1]) begin
            s_d.car_cnt  = 8'h00;
            s_d.car_lost = 1'b0;
         end else if (s_q.car_cnt < 8'(`SMC_CARRIER_LOSS_MS)) begin
            s_d.car_cnt = s_q.car_cnt + 8'h01;
         end else if (!s_q.car_lost) begin
            s_d.car_lost = 1'b1;
            s_d.ev_valid = 1'b1;
            s_d.ev_code  = `SMC_EV_CARRIER_LOSS;
         end
         // carrier wait: remote keeps carrier while we want to send
         if (s_q.hdx && s_q.car_s[1] && tx_request) begin
            if (s_q.cw_cnt < 10'(`SMC_CWAIT_MS)) begin
               s_d.cw_cnt = s_q.cw_cnt + 10'h001;
            end else begin
               s_d.cw_flag = 1'b1;
            end
         end else begin
            s_d.cw_cnt  = 10'h000;
            s_d.cw_flag = 1'b0;
         end
         // call timer and reinit wait
         case (s_q.call_st)
            SMC_CALL_IDLE: begin
               if (point_to_point && s_q.rdy_s[1] && !s_q.rdy_smp) begin
                  s_d.call_st  = SMC_CALL_RUN;
                  s_d.call_cnt = 17'h00000;
               end
            end
            SMC_CALL_RUN: begin
               if (reached(s_q.call_cnt, 17'(`SMC_CALL_TIMEOUT_MS - 1))) begin
                  s_d.call_st   = SMC_CALL_WAIT;
                  s_d.call_cnt  = 17'h00000;
                  s_d.dtr_block = 1'b1;
                  s_d.ev_valid  = 1'b1;
                  s_d.ev_code   = `SMC_EV_DISCONNECT;
               end else begin
                  s_d.call_cnt = s_q.call_cnt + 17'h00001;
               end
            end
            SMC_CALL_WAIT: begin
               if (reached(s_q.call_cnt, 17'(`SMC_REINIT_WAIT_MS - 1))) begin
                  s_d.call_st   = SMC_CALL_IDLE;
                  s_d.dtr_block = 1'b0;
                  s_d.reinit    = 1'b1;
                  s_d.rdy_seen  = 1'b0;
               end else begin
                  s_d.call_cnt = s_q.call_cnt + 17'h00001;
               end
            end
            default: s_d.call_st = SMC_CALL_IDLE;
         endcase
         // cts release timing after an error drop
         case (s_q.cts_st)
            SMC_CTS_WAIT: begin
               if (!s_q.cts_s[1]) begin
                  s_d.cts_st = SMC_CTS_IDLE;
               end else if (s_q.cts_cnt < 7'(`SMC_CTS_REL_MS)) begin
                  s_d.cts_cnt = s_q.cts_cnt + 7'h01;
               end else begin
                  s_d.cts_st   = SMC_CTS_HOLD;
                  s_d.cts_flag = 1'b1;
               end
            end
            SMC_CTS_HOLD: begin
               if (!s_q.cts_s[1] || !line_error) begin
                  s_d.cts_st = SMC_CTS_IDLE;
               end
            end
            default: s_d.cts_st = SMC_CTS_IDLE;
         endcase
      end
      // header stops the call timer at once
      if (s_q.call_st == SMC_CALL_RUN && header_valid) begin
         s_d.call_st = SMC_CALL_IDLE;
      end
      // error drop starts cts release timing
      if (line_error && s_q.cts_st == SMC_CTS_IDLE && !s_q.hdx) begin
         s_d.cts_st   = SMC_CTS_WAIT;
         s_d.cts_cnt  = 7'h00;
         s_d.cts_flag = 1'b0;
      end
      s_d.status = {s_q.tm_s[1], s_q.ring_s[1], ctl_q[0] && !s_q.dtr_block, rts_int,
                    s_q.hdx, s_q.rdy_s[1], s_q.cts_s[1], s_q.car_s[1]};
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs
   assign request_to_send     = rts_int;
   assign data_terminal_ready = ctl_q[0] && !s_q.dtr_block;
   assign standby_select      = ctl_q[1];
   assign remote_loopback     = ctl_q[2];
   assign local_loopback      = ctl_q[3];
   assign new_signal          = ctl_q[4];
   assign freq_select         = ctl_q[5];
   assign silo_to_sync_serial_transceiver = tx_gate && silo_has_data;
   assign rx_enable           = !(s_q.hdx && tx_active);
   assign half_duplex         = s_q.hdx;
   assign modem_status        = s_q.status;
   assign event_valid         = s_q.ev_valid;
   assign event_code          = s_q.ev_code;
   assign carrier_wait_timeout = s_q.cw_flag;
   assign cts_release_timeout = s_q.cts_flag;
   assign line_reinit         = s_q.reinit;

   AST_RTS_LOCK: assert property (@(posedge ref_clk) disable iff (srst)
      !s_q.rdy_s[1] |-> !request_to_send) else $error("rts without modem ready");
   AST_HDX_CAR: assert property (@(posedge ref_clk) disable iff (srst)
      (s_q.hdx && s_q.car_s[1]) |-> (!request_to_send && !silo_to_sync_serial_transceiver))
      else $error("half duplex carrier did not block");
   AST_HDX_RX: assert property (@(posedge ref_clk) disable iff (srst)
      (half_duplex && tx_active) |-> !rx_enable) else $error("rx on while sending");
   AST_FDX_RTS: assert property (@(posedge ref_clk) disable iff (srst)
      (!s_q.hdx && s_q.rdy_s[1] && line_error) |-> !request_to_send)
      else $error("rts kept on line error");
   AST_HDX_MODE: assert property (@(posedge ref_clk) disable iff (srst)
      (!mode_cmd_valid) |=> $stable(half_duplex)) else $error("half duplex changed");
   AST_EVT_TICK: assert property (@(posedge ref_clk) disable iff (srst)
      event_valid |-> $past(s_q.tick)) else $error("event off tick");
   AST_EVT_PULSE: assert property (@(posedge ref_clk) disable iff (srst)
      event_valid |=> !event_valid) else $error("event longer than a cycle");
   AST_DTR_BLOCK: assert property (@(posedge ref_clk) disable iff (srst)
      (s_q.call_st == SMC_CALL_WAIT) |-> !data_terminal_ready)
      else $error("dtr on during reinit wait");
   AST_REINIT: assert property (@(posedge ref_clk) disable iff (srst)
      line_reinit |-> $past(s_q.call_st) == SMC_CALL_WAIT) else $error("bad reinit");

   // named steps of the watcher flows; each must show its effect a cycle later
   sequence ready_fall_seen;
      s_q.tick && s_q.rdy_seen && s_q.rdy_smp && !s_q.rdy_s[1];
   endsequence : ready_fall_seen
   sequence ring_held;
      s_q.tick && s_q.ring_arm && s_q.ring_s[1];
   endsequence : ring_held
   sequence carrier_gone;
      s_q.tick && !s_q.car_s[1] && !s_q.car_lost
      && (s_q.car_cnt >= 8'(`SMC_CARRIER_LOSS_MS));
   endsequence : carrier_gone
   sequence ppt_ready_rise;
      s_q.tick && (s_q.call_st == SMC_CALL_IDLE) && point_to_point
      && s_q.rdy_s[1] && !s_q.rdy_smp;
   endsequence : ppt_ready_rise
   sequence call_expiry;
      s_q.tick && (s_q.call_st == SMC_CALL_RUN) && !header_valid
      && reached(s_q.call_cnt, 17'(`SMC_CALL_TIMEOUT_MS - 1));
   endsequence : call_expiry
   sequence reinit_due;
      s_q.tick && (s_q.call_st == SMC_CALL_WAIT)
      && reached(s_q.call_cnt, 17'(`SMC_REINIT_WAIT_MS - 1));
   endsequence : reinit_due
   sequence link_held;
      s_q.tick && s_q.hdx && s_q.car_s[1] && tx_request
      && (s_q.cw_cnt >= 10'(`SMC_CWAIT_MS));
   endsequence : link_held
   sequence cts_never_fell;
      s_q.tick && (s_q.cts_st == SMC_CTS_WAIT) && s_q.cts_s[1]
      && (s_q.cts_cnt >= 7'(`SMC_CTS_REL_MS));
   endsequence : cts_never_fell

   // watcher reports and ready sampling; simultaneous events may overwrite the code, not the strobe
   AST_RDY_EVENT: assert property (@(posedge ref_clk) disable iff (srst)
      ready_fall_seen |=> event_valid) else $error("ready drop not reported");
   AST_RING_EVENT: assert property (@(posedge ref_clk) disable iff (srst)
      ring_held |=> event_valid) else $error("ring not reported");
   AST_CAR_EVENT: assert property (@(posedge ref_clk) disable iff (srst)
      carrier_gone |=> event_valid) else $error("carrier loss not reported");
   AST_RDY_SAMPLE: assert property (@(posedge ref_clk) disable iff (srst)
      s_q.tick |=> (s_q.rdy_smp == $past(s_q.rdy_s[1]))) else $error("ready missed");
   // call timer start, stop, expiry and the reinit that follows
   AST_CALL_START: assert property (@(posedge ref_clk) disable iff (srst)
      ppt_ready_rise |=> (s_q.call_st == SMC_CALL_RUN)) else $error("call timer idle");
   AST_CALL_HEADER: assert property (@(posedge ref_clk) disable iff (srst)
      (s_q.call_st == SMC_CALL_RUN && header_valid) |=> (s_q.call_st == SMC_CALL_IDLE))
      else $error("header did not stop call timer");
   AST_CALL_EXPIRE: assert property (@(posedge ref_clk) disable iff (srst)
      call_expiry |=> (event_valid && event_code == `SMC_EV_DISCONNECT
      && !data_terminal_ready)) else $error("call expiry not handled");
   AST_REINIT_DUE: assert property (@(posedge ref_clk) disable iff (srst)
      reinit_due |=> line_reinit) else $error("reinit pulse missing");
   // timeout flags, the cts interlock, full duplex rts and full duplex receiver
   AST_CW_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
      link_held |=> carrier_wait_timeout) else $error("carrier wait not flagged");
   AST_CTS_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
      cts_never_fell |=> cts_release_timeout) else $error("cts release not flagged");
   AST_CTS_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
      (!cts_interlock_bypass && s_q.cts_st == SMC_CTS_HOLD) |-> !request_to_send)
      else $error("rts during cts hold");
   AST_FDX_RTS_ON: assert property (@(posedge ref_clk) disable iff (srst)
      (!s_q.hdx && s_q.rdy_s[1] && !line_error && s_q.cts_st != SMC_CTS_HOLD)
      |-> request_to_send) else $error("rts dropped without error");
   AST_FDX_RX: assert property (@(posedge ref_clk) disable iff (srst)
      !half_duplex |-> rx_enable) else $error("receiver off in full duplex");
   // status word, host controls and tick wrap
   AST_STATUS_HDX: assert property (@(posedge ref_clk) disable iff (srst)
      1'b1 |=> (modem_status[3] == $past(s_q.hdx))) else $error("status hdx stale");
   AST_STATUS_DTR: assert property (@(posedge ref_clk) disable iff (srst)
      1'b1 |=> (modem_status[5] == $past(data_terminal_ready))) else $error("status dtr stale");
   AST_CTL_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
      wr_ctl_valid |=> ({freq_select, new_signal, local_loopback, remote_loopback,
      standby_select} == $past(wr_ctl_data[5:1]))) else $error("control write lost");
   AST_TICK_WRAP: assert property (@(posedge ref_clk) disable iff (srst)
      s_q.tick |-> (s_q.tick_cnt == 17'h00000)) else $error("tick off wrap");
endmodule : smc_modem_ctl

// ---- testbench/smc_modem_model.sv ----
// behavioural modem on the far side of the supervisor pins
module smc_modem_model (
   input  wire logic ref_clk,
   input  wire logic want_ready,
   input  wire logic want_ring,
   input  wire logic want_carrier,
   input  wire logic rts,
   input  wire logic local_loop,
   input  wire logic cts_stuck,
   output logic      modem_ready,
   output logic      ring_detect,
   output logic      carrier_detect,
   output logic      clear_to_send,
   output logic      test_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cts_dly = 2'h0;
   // cts answers rts two cycles late, like a slow turnaround modem
   always @(posedge ref_clk) begin
      cts_dly <= {cts_dly[0], rts};
   end
   assign modem_ready    = want_ready;
   assign ring_detect    = want_ring;
   assign carrier_detect = want_carrier;
   // a constant cts modem never lets clear to send fall
   assign clear_to_send  = cts_stuck || cts_dly[1];
   assign test_mode      = local_loop; // loopback answers with test mode on
endmodule : smc_modem_model

// ---- testbench/tb.sv ----
// self-checking bench for the modem control supervisor
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TCK = 1; // tick every cycle keeps the 65 s call timer in budget
   logic       ref_clk = 1'b0, srst = 1'b1;
   logic       w_rdy = 1'b0, w_ring = 1'b0, w_car = 1'b1;
   logic       rdy, ring, car, cts, tm, lerr = 1'b0, txa = 1'b0;
   logic       mvalid = 1'b0, mhdx = 1'b0, wvalid = 1'b0;
   logic       p2p = 1'b0, hv = 1'b0, byp = 1'b1, stuck = 1'b0;
   int         n;
   logic [5:0] wdata = 6'h00;
   logic       rts, dtr, stby, rlb, llb, nsig, freq, silo, rxe, hdx, evv;
   logic       cwto, ctsto, reinit;
   logic [7:0] stat;
   logic [1:0] evc;
   int         err_count = 0;
   int         samples_checked = 0;
   always #4 ref_clk = ~ref_clk;
   smc_modem_model modem (.ref_clk(ref_clk), .want_ready(w_rdy), .want_ring(w_ring),
      .want_carrier(w_car), .rts(rts), .local_loop(llb), .cts_stuck(stuck), .modem_ready(rdy),
      .ring_detect(ring), .carrier_detect(car), .clear_to_send(cts), .test_mode(tm));
   smc_modem_ctl #(.TICK_CYCLES(TCK)) dut (.ref_clk(ref_clk), .srst(srst),
      .modem_ready(rdy), .ring_detect(ring), .carrier_detect(car), .clear_to_send(cts),
      .test_mode(tm), .point_to_point(p2p), .header_valid(hv), .line_error(lerr),
      .cts_interlock_bypass(byp), .tx_request(1'b1), .tx_active(txa),
      .silo_has_data(1'b1), .mode_cmd_valid(mvalid), .mode_half_duplex(mhdx),
      .wr_ctl_valid(wvalid), .wr_ctl_data(wdata), .request_to_send(rts),
      .data_terminal_ready(dtr), .standby_select(stby), .remote_loopback(rlb),
      .local_loopback(llb), .new_signal(nsig), .freq_select(freq),
      .silo_to_sync_serial_transceiver(silo), .rx_enable(rxe), .half_duplex(hdx),
      .modem_status(stat), .event_valid(evv), .event_code(evc),
      .carrier_wait_timeout(cwto), .cts_release_timeout(ctsto), .line_reinit(reinit));
   // inputs move only on the falling edge
   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task give_verdict;
      if (err_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // bounded wait for an event pulse, then check its code and width
   task wait_ev(input logic [1:0] code);
      int i;
      for (i = 0; i < 4000 && evv !== 1'b1; i++)
         cyc(1);
      if (i == 4000) begin
         chk("event_valid", 8'h01, {7'h00, evv});
         give_verdict();
      end
      chk("event_code", {6'h00, code}, {6'h00, evc});
      cyc(1);
      chk("event_pulse_end", 8'h00, {7'h00, evv});
   endtask : wait_ev
   // bounded wait for rts to reach a level
   task wait_rts(input logic lvl);
      int i;
      for (i = 0; i < 200 && rts !== lvl; i++)
         cyc(1);
      chk("request_to_send", {7'h00, lvl}, {7'h00, rts});
   endtask : wait_rts
   initial begin
      cyc(5);
      srst = 1'b0;
      chk("rx_enable_reset", 8'h01, {7'h00, rxe});
      cyc(100);
      chk("rts_no_ready", 8'h00, {7'h00, rts});
      wvalid = 1'b1;
      wdata  = 6'h3f;
      cyc(1);
      wvalid = 1'b0;
      chk("ctl_outputs", 8'h3f, {2'h0, freq, nsig, llb, rlb, stby, dtr});
      wdata = 6'h00;
      w_rdy = 1'b1;
      wait_rts(1'b1);
      // cts trails rts by the model's two cycles plus sync and status lag
      cyc(6);
      chk("status_full", 8'hb7, stat);
      lerr = 1'b1;
      wait_rts(1'b0);
      lerr = 1'b0;
      wait_rts(1'b1);
      mvalid = 1'b1;
      mhdx   = 1'b1;
      cyc(1);
      mvalid = 1'b0;
      chk("half_duplex", 8'h01, {7'h00, hdx});
      wait_rts(1'b0);
      chk("silo_gate", 8'h00, {7'h00, silo});
      txa = 1'b1;
      cyc(1);
      chk("rx_enable_tx", 8'h00, {7'h00, rxe});
      txa = 1'b0;
      cyc(1);
      chk("rx_enable_idle", 8'h01, {7'h00, rxe});
      w_ring = 1'b1;
      wait_ev(2'h2);
      w_car = 1'b0;
      cyc(126 * TCK);
      chk("no_early_loss", 8'h00, {7'h00, evv});
      wait_ev(2'h3);
      w_car = 1'b1;
      for (n = 0; n < 1100 && cwto !== 1'b1; n++)
         cyc(1);
      chk("carrier_wait_timeout", 8'h01, {7'h00, cwto});
      mvalid = 1'b1;
      mhdx   = 1'b0;
      cyc(1);
      mvalid = 1'b0;
      cyc(1);
      chk("carrier_wait_clear", 8'h00, {7'h00, cwto});
      byp   = 1'b0;
      stuck = 1'b1;
      lerr  = 1'b1;
      for (n = 0; n < 200 && ctsto !== 1'b1; n++)
         cyc(1);
      chk("cts_release_timeout", 8'h01, {7'h00, ctsto});
      lerr = 1'b0;
      #1;
      chk("rts_interlock_hold", 8'h00, {7'h00, rts});
      cyc(2);
      chk("rts_after_hold", 8'h01, {7'h00, rts});
      stuck = 1'b0;
      byp   = 1'b1;
      w_rdy = 1'b0;
      wait_ev(2'h1);
      // header stops the first call; a broken stop would expire early
      p2p   = 1'b1;
      w_rdy = 1'b1;
      cyc(10);
      hv = 1'b1;
      cyc(1);
      hv = 1'b0;
      cyc(100);
      w_rdy = 1'b0;
      wait_ev(2'h1);
      w_rdy = 1'b1;
      for (n = 0; n < 70000 && evv !== 1'b1; n++)
         cyc(1);
      chk("call_timer_length", 8'h01, {7'h00, n >= 64990});
      wait_ev(2'h1);
      chk("dtr_after_expiry", 8'h00, {7'h00, dtr});
      for (n = 0; n < 3100 && reinit !== 1'b1; n++)
         cyc(1);
      chk("line_reinit", 8'h01, {7'h00, reinit});
      cyc(1);
      chk("dtr_after_reinit", 8'h01, {7'h00, dtr});
      give_verdict();
   end
endmodule : tb
